// file: design/adc_win_pkg.sv
/*
 * Constants and carrier types for the converter window detector and input selector.
 * Assumes an 8-bit special-function register port and a 16-bit conversion word.
 */
package adc_win_pkg;
	// register addresses in the special-function register space
	localparam logic [7:0] CHSEL_ADDR = 8'hBB;
	localparam logic [7:0] UPLO_ADDR = 8'hC3;
	localparam logic [7:0] UPHI_ADDR = 8'hC4;
	localparam logic [7:0] LOLO_ADDR = 8'hC5;
	localparam logic [7:0] LOHI_ADDR = 8'hC6;
	// values after reset
	localparam logic [4:0] CHSEL_RST = 5'h1F;
	localparam logic [7:0] UPLO_RST = 8'hFF;
	localparam logic [7:0] UPHI_RST = 8'hFF;
	localparam logic [7:0] LOLO_RST = 8'h00;
	localparam logic [7:0] LOHI_RST = 8'h00;
	// field positions
	localparam int CODE_LSB = 0;
	localparam int CODE_MSB = 4;
	localparam int RESULT_BITS = 10;
	// positive input codes
	localparam logic [4:0] CODE_P0_LAST = 5'h07;
	localparam logic [4:0] CODE_P1_FIRST = 5'h0C;
	localparam logic [4:0] CODE_P1_LAST = 5'h0F;
	localparam logic [4:0] CODE_P2_FIRST = 5'h10;
	localparam logic [4:0] CODE_P2_LAST = 5'h13;
	localparam logic [4:0] CODE_TEMP = 5'h1B;
	localparam logic [4:0] CODE_VBAT = 5'h1C;
	localparam logic [4:0] CODE_VREG = 5'h1D;
	localparam logic [4:0] CODE_VDC = 5'h1E;
	localparam logic [4:0] CODE_GND = 5'h1F;

	typedef enum logic [3:0] {
		SRC_PORT0 = 4'h0,
		SRC_PORT1 = 4'h1,
		SRC_PORT2 = 4'h2,
		SRC_TEMP = 4'h3,
		SRC_VBAT = 4'h4,
		SRC_VREG = 4'h5,
		SRC_VDC = 4'h6,
		SRC_GND = 4'h7,
		SRC_RSVD = 4'h8
	} mux_source_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

	typedef struct packed {
		mux_source_t src;
		logic [2:0] pin;
	} mux_sel_t;

	typedef struct packed {
		logic [4:0] code;
		logic [15:0] upper;
		logic [15:0] lower;
		logic flag;
		logic [7:0] rdata;
		mux_sel_t mux;
		logic sensor_hiz;
	} state_t;
endpackage

// file: design/adc_window_compare_and_input_select.sv
/*
 * Window comparator and positive-input selector around a single-ended converter.
 * Assumes a synchronous special-function register port (one-cycle read and write strobes),
 * a one-cycle result_valid pulse from the converter, and a one-cycle flag clear strobe
 * from the converter control register that lives outside this block.
 */
// Summary of operation
// RULE_01 - upper limit low byte, read/write, resets ones
// RULE_02 - lower limit bytes read/write, reset to zero
// RULE_03 - software zeroes low bytes in 8-bit mode
// RULE_04 - inside window: above upper and below lower
// RULE_05 - outside window: below lower or above upper
// RULE_06 - result is unsigned, zero means ground
// RULE_07 - five-bit channel code, resets to ground code
// RULE_08 - port pin codes decode, gaps reserved
// RULE_09 - internal sources and ground at top codes
// RULE_10 - channel register bits 7:5 read zero
// RULE_11 - sensor output high impedance while disabled
// RULE_12 - software selects and enables sensor together
// RULE_13 - upper limit high byte, read/write
// RULE_14 - window flag read or polled by control
// RULE_15 - limit order chooses inside or outside mode
// RULE_16 - compare on result update, flag sticky
`timescale 1ns/1ns
module adc_window_compare_and_input_select #(
	parameter int DATA_W = 16
) (
	input wire logic clock, // system clock
	input wire logic rstn, // asynchronous reset, active low
	input wire adc_win_pkg::sfr_req_t sfr_req, // register strobes, address, write data
	output logic [7:0] sfr_rdata, // read data, valid the cycle after rd
	input wire logic result_valid, // conversion word updated this cycle
	input wire logic [DATA_W-1:0] result_word, // high byte and low byte of the result
	input wire logic flag_clear, // software clears the window flag
	input wire logic temp_sensor_enable, // sensor enable bit from reference control
	output logic window_hit_flag, // sticky window flag
	output adc_win_pkg::mux_sel_t analog_input_mux, // decoded positive input
	output logic sensor_hiz // sensor output left floating
);
	// refuse widths that the byte-wide limit registers cannot serve
	if (DATA_W != 16) begin : g_bad_width
		$error("DATA_W must be 16");
	end

	adc_win_pkg::state_t st_ff;
	adc_win_pkg::state_t nxt_st;
	logic inside_mode;
	logic hit;

	// window compare on the fresh result word
	always_comb begin
		inside_mode = st_ff.lower > st_ff.upper; // RULE_15
		if (inside_mode) begin
			hit = (result_word > st_ff.upper) && (result_word < st_ff.lower); // RULE_04 RULE_06
		end else begin
			hit = (result_word < st_ff.lower) || (result_word > st_ff.upper); // RULE_05 RULE_06
		end
	end

	// next state: register writes, reads, flag and mux decode
	always_comb begin
		nxt_st = st_ff;
		if (sfr_req.wr) begin
			unique case (sfr_req.addr)
				adc_win_pkg::CHSEL_ADDR: nxt_st.code = sfr_req.wdata[4:0]; // RULE_07 RULE_10
				adc_win_pkg::UPLO_ADDR: nxt_st.upper[7:0] = sfr_req.wdata; // RULE_01
				adc_win_pkg::UPHI_ADDR: nxt_st.upper[15:8] = sfr_req.wdata; // RULE_13
				adc_win_pkg::LOLO_ADDR: nxt_st.lower[7:0] = sfr_req.wdata; // RULE_02
				adc_win_pkg::LOHI_ADDR: nxt_st.lower[15:8] = sfr_req.wdata; // RULE_02
				default: ;
			endcase
		end
		if (sfr_req.rd) begin
			unique case (sfr_req.addr)
				adc_win_pkg::CHSEL_ADDR: nxt_st.rdata = {3'h0, st_ff.code}; // RULE_10
				adc_win_pkg::UPLO_ADDR: nxt_st.rdata = st_ff.upper[7:0]; // RULE_01
				adc_win_pkg::UPHI_ADDR: nxt_st.rdata = st_ff.upper[15:8]; // RULE_13
				adc_win_pkg::LOLO_ADDR: nxt_st.rdata = st_ff.lower[7:0]; // RULE_02
				adc_win_pkg::LOHI_ADDR: nxt_st.rdata = st_ff.lower[15:8]; // RULE_02
				default: nxt_st.rdata = 8'h00;
			endcase
		end
		// a hit in the clearing cycle wins over the clear
		if (result_valid && hit) begin
			nxt_st.flag = 1'b1; // RULE_16 RULE_14
		end else if (flag_clear) begin
			nxt_st.flag = 1'b0;
		end
		// decode the held channel code
		nxt_st.mux.pin = 3'h0;
		if (st_ff.code <= adc_win_pkg::CODE_P0_LAST) begin
			nxt_st.mux.src = adc_win_pkg::SRC_PORT0; // RULE_08
			nxt_st.mux.pin = st_ff.code[2:0];
		end else if (st_ff.code >= adc_win_pkg::CODE_P1_FIRST &&
			st_ff.code <= adc_win_pkg::CODE_P1_LAST) begin
			nxt_st.mux.src = adc_win_pkg::SRC_PORT1; // RULE_08
			nxt_st.mux.pin = {1'b1, st_ff.code[1:0]};
		end else if (st_ff.code >= adc_win_pkg::CODE_P2_FIRST &&
			st_ff.code <= adc_win_pkg::CODE_P2_LAST) begin
			nxt_st.mux.src = adc_win_pkg::SRC_PORT2; // RULE_08
			nxt_st.mux.pin = {1'b0, st_ff.code[1:0]};
		end else if (st_ff.code == adc_win_pkg::CODE_TEMP) begin
			nxt_st.mux.src = adc_win_pkg::SRC_TEMP; // RULE_09
		end else if (st_ff.code == adc_win_pkg::CODE_VBAT) begin
			nxt_st.mux.src = adc_win_pkg::SRC_VBAT; // RULE_09
		end else if (st_ff.code == adc_win_pkg::CODE_VREG) begin
			nxt_st.mux.src = adc_win_pkg::SRC_VREG; // RULE_09
		end else if (st_ff.code == adc_win_pkg::CODE_VDC) begin
			nxt_st.mux.src = adc_win_pkg::SRC_VDC; // RULE_09
		end else if (st_ff.code == adc_win_pkg::CODE_GND) begin
			nxt_st.mux.src = adc_win_pkg::SRC_GND; // RULE_09
		end else begin
			nxt_st.mux.src = adc_win_pkg::SRC_RSVD; // RULE_08
		end
		nxt_st.sensor_hiz = !temp_sensor_enable; // RULE_11
	end

	// single state register
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_ff.code <= adc_win_pkg::CHSEL_RST; // RULE_07
			st_ff.upper <= {adc_win_pkg::UPHI_RST, adc_win_pkg::UPLO_RST}; // RULE_01
			st_ff.lower <= {adc_win_pkg::LOHI_RST, adc_win_pkg::LOLO_RST}; // RULE_02
			st_ff.flag <= 1'b0;
			st_ff.rdata <= 8'h00;
			st_ff.mux.src <= adc_win_pkg::SRC_GND;
			st_ff.mux.pin <= 3'h0;
			st_ff.sensor_hiz <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// outputs straight from the state register
	assign sfr_rdata = st_ff.rdata;
	assign window_hit_flag = st_ff.flag;
	assign analog_input_mux = st_ff.mux;
	assign sensor_hiz = st_ff.sensor_hiz;

	// checks next to the logic
	property p_inside_hit;
		@(posedge clock) disable iff (!rstn)
		result_valid && (st_ff.lower > st_ff.upper) && (result_word > st_ff.upper) &&
			(result_word < st_ff.lower) |=> window_hit_flag;
	endproperty
	a_inside_hit: assert property (p_inside_hit) else $error("inside hit not flagged"); // RULE_04

	property p_outside_hit;
		@(posedge clock) disable iff (!rstn)
		result_valid && !(st_ff.lower > st_ff.upper) &&
			((result_word < st_ff.lower) || (result_word > st_ff.upper)) |=> window_hit_flag;
	endproperty
	a_outside_hit: assert property (p_outside_hit) else $error("outside hit not flagged"); // RULE_05

	property p_mode_select;
		@(posedge clock) disable iff (!rstn)
		result_valid && (st_ff.lower > st_ff.upper) && (result_word <= st_ff.upper) &&
			!flag_clear && !window_hit_flag |=> !window_hit_flag;
	endproperty
	a_mode_select: assert property (p_mode_select) else $error("inside mode flagged low word"); // RULE_15

	property p_flag_sticky;
		@(posedge clock) disable iff (!rstn)
		window_hit_flag && !flag_clear |=> window_hit_flag [*1] ##0 $stable(window_hit_flag);
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without clear"); // RULE_16

	property p_flag_clear;
		@(posedge clock) disable iff (!rstn)
		flag_clear && !result_valid |=> !window_hit_flag;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag clear ignored"); // RULE_14

	property p_chsel_read;
		@(posedge clock) disable iff (!rstn)
		sfr_req.wr && (sfr_req.addr == adc_win_pkg::CHSEL_ADDR) ##1
			sfr_req.rd && (sfr_req.addr == adc_win_pkg::CHSEL_ADDR)
			|=> sfr_rdata == {3'h0, $past(sfr_req.wdata[4:0], 2)};
	endproperty
	a_chsel_read: assert property (p_chsel_read) else $error("channel read back wrong"); // RULE_10

	property p_upper_low_write;
		@(posedge clock) disable iff (!rstn)
		sfr_req.wr && (sfr_req.addr == adc_win_pkg::UPLO_ADDR) ##1
			sfr_req.rd && (sfr_req.addr == adc_win_pkg::UPLO_ADDR)
			|=> sfr_rdata == $past(sfr_req.wdata, 2);
	endproperty
	a_upper_low_write: assert property (p_upper_low_write) else $error("upper low byte lost"); // RULE_01

	property p_temp_decode;
		@(posedge clock) disable iff (!rstn)
		sfr_req.wr && (sfr_req.addr == adc_win_pkg::CHSEL_ADDR) &&
			(sfr_req.wdata[4:0] == adc_win_pkg::CODE_TEMP)
			|=> ##1 analog_input_mux.src == adc_win_pkg::SRC_TEMP;
	endproperty
	a_temp_decode: assert property (p_temp_decode) else $error("sensor code not decoded"); // RULE_09

	property p_sensor_hiz;
		@(posedge clock) disable iff (!rstn)
		!temp_sensor_enable |=> sensor_hiz;
	endproperty
	a_sensor_hiz: assert property (p_sensor_hiz) else $error("sensor driven while disabled"); // RULE_11

	c_inside_hit: cover property (@(posedge clock) disable iff (!rstn)
		result_valid && (st_ff.lower > st_ff.upper) && hit);
	c_outside_hit: cover property (@(posedge clock) disable iff (!rstn)
		result_valid && (st_ff.lower < st_ff.upper) && hit);
	c_hit_on_clear: cover property (@(posedge clock) disable iff (!rstn)
		result_valid && hit && flag_clear);
	c_temp_measure: cover property (@(posedge clock) disable iff (!rstn)
		(analog_input_mux.src == adc_win_pkg::SRC_TEMP) && !sensor_hiz);
endmodule

// file: sim/testbench.sv
/*
 * Self-checking bench for the window comparator and positive-input selector.
 * Assumes the design package is compiled first and the one-cycle register read latency.
 */
`timescale 1ns/1ns
module testbench;
	logic clock, rstn, result_valid, flag_clear, temp_sensor_enable, window_hit_flag, sensor_hiz;
	adc_win_pkg::sfr_req_t sfr_req;
	adc_win_pkg::mux_sel_t analog_input_mux;
	logic [7:0] sfr_rdata;
	logic [15:0] result_word;
	int miscompares, n_compared, cycles;
	adc_window_compare_and_input_select i_dut (.clock(clock), .rstn(rstn), .sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata), .result_valid(result_valid), .result_word(result_word),
		.flag_clear(flag_clear), .temp_sensor_enable(temp_sensor_enable),
		.window_hit_flag(window_hit_flag), .analog_input_mux(analog_input_mux),
		.sensor_hiz(sensor_hiz));
	// clock and cycle ceiling
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares = miscompares + 1;
			print_verdict();
		end
	end
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock) sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clock) sfr_req <= '0;
	endtask
	// write then read the same register in back-to-back cycles
	task automatic wr_rd_chk(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
		@(posedge clock) sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clock) sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clock) sfr_req <= '0;
		#1 chk("write then read", 16'(exp), 16'(sfr_rdata));
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock) sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clock) sfr_req <= '0;
		#1 chk("register read", 16'(exp), 16'(sfr_rdata));
	endtask
	function automatic logic exp_hit(input logic [15:0] up, lo, w);
		return (lo > up) ? (w > up && w < lo) : (w < lo || w > up);
	endfunction
	function automatic adc_win_pkg::mux_sel_t exp_mux(input logic [4:0] c);
		case (c) inside
			[5'h00:5'h07]: return '{adc_win_pkg::SRC_PORT0, c[2:0]};
			[5'h0C:5'h0F]: return '{adc_win_pkg::SRC_PORT1, c[2:0]};
			[5'h10:5'h13]: return '{adc_win_pkg::SRC_PORT2, c[2:0]};
			5'h1B: return '{adc_win_pkg::SRC_TEMP, 3'h0};
			5'h1C: return '{adc_win_pkg::SRC_VBAT, 3'h0};
			5'h1D: return '{adc_win_pkg::SRC_VREG, 3'h0};
			5'h1E: return '{adc_win_pkg::SRC_VDC, 3'h0};
			5'h1F: return '{adc_win_pkg::SRC_GND, 3'h0};
			default: return '{adc_win_pkg::SRC_RSVD, 3'h0};
		endcase
	endfunction
	// reset values of every register, the mux and sensor outputs and an unmapped read
	task automatic test_reset();
		chk("mux after reset", 16'(exp_mux(5'h1F)), 16'(analog_input_mux));
		chk("sensor float", 16'h0001, 16'(sensor_hiz));
		rd_chk(8'hBB, 8'h1F);
		rd_chk(8'hC3, 8'hFF);
		rd_chk(8'hC4, 8'hFF);
		rd_chk(8'hC5, 8'h00);
		rd_chk(8'hC6, 8'h00);
		wr(8'hC7, 8'h5A);
		rd_chk(8'hC7, 8'h00);
		$display("test reset done");
	endtask
	// every channel code with the unused upper bits set on write
	task automatic test_mux();
		for (int c = 0; c < 32; c++) begin
			wr_rd_chk(8'hBB, 8'hE0 | 8'(c), 8'(c));
			repeat (2) @(posedge clock);
			#1 chk("mux decode", 16'(exp_mux(5'(c))), 16'(analog_input_mux));
			rd_chk(8'hBB, 8'(c));
		end
		$display("test mux done");
	endtask
	// set both limits, then send words around the edges of the window
	task automatic test_window(input logic [15:0] up, input logic [15:0] lo);
		logic [15:0] ws [6];
		ws = '{up - 16'h1, up, up + 16'h1, lo - 16'h1, lo, lo + 16'h1};
		wr_rd_chk(8'hC3, up[7:0], up[7:0]);
		wr(8'hC4, up[15:8]);
		wr(8'hC5, lo[7:0]);
		wr(8'hC6, lo[15:8]);
		rd_chk(8'hC4, up[15:8]);
		rd_chk(8'hC5, lo[7:0]);
		foreach (ws[i]) begin
			@(posedge clock) begin
				result_valid <= 1'b1;
				result_word <= ws[i];
			end
			@(posedge clock) result_valid <= 1'b0;
			#1 chk("window flag", 16'(exp_hit(up, lo, ws[i])), 16'(window_hit_flag));
			@(posedge clock);
			#1 chk("flag sticky", 16'(exp_hit(up, lo, ws[i])), 16'(window_hit_flag));
			@(posedge clock) flag_clear <= 1'b1;
			@(posedge clock) flag_clear <= 1'b0;
			#1 chk("flag cleared", 16'h0000, 16'(window_hit_flag));
		end
		// a hit in the clearing cycle keeps the flag set
		@(posedge clock) begin
			result_valid <= 1'b1;
			result_word <= ws[2];
			flag_clear <= 1'b1;
		end
		@(posedge clock) begin
			result_valid <= 1'b0;
			flag_clear <= 1'b0;
		end
		#1 chk("set beats clear", 16'h0001, 16'(window_hit_flag));
		@(posedge clock) flag_clear <= 1'b1;
		@(posedge clock) flag_clear <= 1'b0;
		#1 chk("flag cleared", 16'h0000, 16'(window_hit_flag));
		$display("test window done");
	endtask
	// sensor enable drives the float indication
	task automatic test_sensor();
		wr(8'hBB, 8'h1B);
		@(posedge clock) temp_sensor_enable <= 1'b1;
		repeat (2) @(posedge clock);
		#1 chk("sensor driven", 16'h0000, 16'(sensor_hiz));
		chk("sensor channel", 16'(exp_mux(5'h1B)), 16'(analog_input_mux));
		@(posedge clock) temp_sensor_enable <= 1'b0;
		repeat (2) @(posedge clock);
		#1 chk("sensor float", 16'h0001, 16'(sensor_hiz));
		$display("test sensor done");
	endtask
	task automatic print_verdict();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		miscompares = 0;
		n_compared = 0;
		cycles = 0;
		rstn = 1'b0;
		sfr_req = '0;
		result_valid = 1'b0;
		result_word = 16'h0000;
		flag_clear = 1'b0;
		temp_sensor_enable = 1'b0;
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		#1 test_reset();
		test_mux();
		test_window(16'h0040, 16'h0080);
		test_window(16'h0080, 16'h0040);
		test_window(16'h03FE, 16'h0200);
		test_window(16'h4000, 16'h8000);
		test_sensor();
		print_verdict();
	end
endmodule
